// file: logic/ccb_pkg.sv
// Purpose: Constants for the controller capability byte table.
// Assumes: Byte offsets are those of the identification data structure.
// Notes: Defaults are plain configuration choices, not product values.
package ccb_pkg;
   // ----------------------------------------------------------------
   // Byte offsets in the identification structure
   // ----------------------------------------------------------------
   localparam logic [9:0] CCB_OFS_FW_CAP = 10'h104;
   localparam logic [9:0] CCB_OFS_LOG_ATTR = 10'h105;
   localparam logic [9:0] CCB_OFS_ERR_LOG = 10'h106;
   localparam logic [9:0] CCB_OFS_PWR_STATE = 10'h107;
   localparam logic [9:0] CCB_OFS_VENDOR_CFG = 10'h108;
   // ----------------------------------------------------------------
   // Field positions and limits
   // ----------------------------------------------------------------
   localparam int CCB_BIT_FLAG = 0;
   localparam logic [5:0] CCB_PWR_STATES_MAX = 6'h20;
   localparam logic [8:0] CCB_ERR_ENTRIES_MAX = 9'h100;
   localparam logic [7:0] CCB_BYTE_RESET = 8'h00;
   // Firmware byte bits 3:1 belong to a neighbouring field; kept at zero
   localparam logic [7:0] CCB_FW_KEEP_MASK = 8'h01;
   localparam logic [7:0] CCB_FLAG_MASK = 8'h01;
endpackage : ccb_pkg

// file: logic/ccb_capability_bytes.sv
// Purpose: Registered capability bytes reported in identification data.
// Assumes: Configuration inputs are static straps, sampled at reset release.
// Notes: Values are latched once after reset and held constant after.
`timescale 1ns/1ps
module ccb_capability_bytes
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic cfg_slot1_read_only,
   input wire logic cfg_health_per_ns,
   input wire logic [8:0] cfg_err_entries,
   input wire logic [5:0] cfg_power_states,
   input wire logic cfg_vendor_std_format,
   input wire logic [9:0] rd_offset,
   output logic [7:0] fw_capability_byte,
   output logic [7:0] log_attribute_byte,
   output logic [7:0] error_log_entry_count,
   output logic [7:0] power_state_count,
   output logic [7:0] vendor_command_config_byte,
   output logic caps_valid,
   output logic [7:0] rd_data,
   output logic rd_hit
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Zero-based encode with clamping into the legal range
   function automatic logic [7:0] ccb_zero_based(input logic [8:0] cnt,
                                                 input logic [8:0] max);
      logic [8:0] c;
      c = cnt;
      if (c == 9'h000)
      begin
         c = 9'h001;
      end
      if (c > max)
      begin
         c = max;
      end
      ccb_zero_based = 8'(c - 9'h001);
   endfunction : ccb_zero_based

   // ----------------------------------------------------------------
   // Capture state
   // ----------------------------------------------------------------
   logic loaded_q;
   logic loaded_d;
   logic [7:0] fw_q, fw_d;
   logic [7:0] la_q, la_d;
   logic [7:0] el_q, el_d;
   logic [7:0] ps_q, ps_d;
   logic [7:0] vc_q, vc_d;
   logic [7:0] rd_q, rd_d;
   logic hit_q, hit_d;

   always_comb
   begin
      loaded_d = 1'b1;
      fw_d = fw_q;
      la_d = la_q;
      el_d = el_q;
      ps_d = ps_q;
      vc_d = vc_q;
      // Capture once only so straps glitching later cannot alter reports
      if (!loaded_q)
      begin
         fw_d = {7'h00, cfg_slot1_read_only} & ccb_pkg::CCB_FW_KEEP_MASK;
         la_d = {7'h00, cfg_health_per_ns} & ccb_pkg::CCB_FLAG_MASK;
         el_d = ccb_zero_based(cfg_err_entries,
                               ccb_pkg::CCB_ERR_ENTRIES_MAX);
         ps_d = ccb_zero_based({3'h0, cfg_power_states},
                               {3'h0, ccb_pkg::CCB_PWR_STATES_MAX});
         vc_d = {7'h00, cfg_vendor_std_format} & ccb_pkg::CCB_FLAG_MASK;
      end
      hit_d = 1'b1;
      case (rd_offset)
         ccb_pkg::CCB_OFS_FW_CAP: rd_d = fw_q;
         ccb_pkg::CCB_OFS_LOG_ATTR: rd_d = la_q;
         ccb_pkg::CCB_OFS_ERR_LOG: rd_d = el_q;
         ccb_pkg::CCB_OFS_PWR_STATE: rd_d = ps_q;
         ccb_pkg::CCB_OFS_VENDOR_CFG: rd_d = vc_q;
         default:
         begin
            rd_d = ccb_pkg::CCB_BYTE_RESET;
            hit_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         loaded_q <= 1'b0;
         fw_q <= ccb_pkg::CCB_BYTE_RESET;
         la_q <= ccb_pkg::CCB_BYTE_RESET;
         el_q <= ccb_pkg::CCB_BYTE_RESET;
         ps_q <= ccb_pkg::CCB_BYTE_RESET;
         vc_q <= ccb_pkg::CCB_BYTE_RESET;
         rd_q <= ccb_pkg::CCB_BYTE_RESET;
         hit_q <= 1'b0;
      end
      else
      begin
         loaded_q <= loaded_d;
         fw_q <= fw_d;
         la_q <= la_d;
         el_q <= el_d;
         ps_q <= ps_d;
         vc_q <= vc_d;
         rd_q <= rd_d;
         hit_q <= hit_d;
      end
   end

   assign fw_capability_byte = fw_q;
   assign log_attribute_byte = la_q;
   assign error_log_entry_count = el_q;
   assign power_state_count = ps_q;
   assign vendor_command_config_byte = vc_q;
   assign caps_valid = loaded_q;
   assign rd_data = rd_q;
   assign rd_hit = hit_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_slot1;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(loaded_q) |-> fw_q[0] == $past(cfg_slot1_read_only);
   endproperty
   a_slot1: assert property (p_slot1)
      else $error("slot flag wrong");

   property p_health;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(loaded_q) |-> la_q[0] == $past(cfg_health_per_ns);
   endproperty
   a_health: assert property (p_health)
      else $error("log flag wrong");

   property p_err;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(loaded_q) && $past(cfg_err_entries) != 9'h000 &&
         $past(cfg_err_entries) <= ccb_pkg::CCB_ERR_ENTRIES_MAX |->
         {1'b0, el_q} == $past(cfg_err_entries) - 9'h001;
   endproperty
   a_err: assert property (p_err) else $error("entry count wrong");

   // Entry counts beyond the byte range saturate
   property p_err_clamp;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(loaded_q) &&
         $past(cfg_err_entries) > ccb_pkg::CCB_ERR_ENTRIES_MAX |->
         el_q == 8'hFF;
   endproperty
   a_err_clamp: assert property (p_err_clamp)
      else $error("entry clamp wrong");

   property p_pwr;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(loaded_q) && $past(cfg_power_states) != 6'h00 &&
         $past(cfg_power_states) <= 6'h20 |->
         ps_q == {2'b00, $past(cfg_power_states) - 6'h01};
   endproperty
   a_pwr: assert property (p_pwr) else $error("state count wrong");

   property p_pwr_max;
      @(posedge core_clk) disable iff (!reset_n)
      loaded_q |-> ps_q <= 8'h1F;
   endproperty
   a_pwr_max: assert property (p_pwr_max)
      else $error("too many states");

   // A zero strap still reports state 0 as present
   property p_pwr_zero;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(loaded_q) && $past(cfg_power_states) == 6'h00 |-> ps_q == 8'h00;
   endproperty
   a_pwr_zero: assert property (p_pwr_zero)
      else $error("state floor wrong");

   property p_vendor;
      @(posedge core_clk) disable iff (!reset_n)
      $rose(loaded_q) |-> vc_q[0] == $past(cfg_vendor_std_format);
   endproperty
   a_vendor: assert property (p_vendor)
      else $error("vendor flag wrong");

   property p_reserved;
      @(posedge core_clk) disable iff (!reset_n)
      la_q[7:1] == 7'h00 && vc_q[7:1] == 7'h00 && fw_q[7:1] == 7'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved set");

   property p_stable;
      @(posedge core_clk) disable iff (!reset_n)
      loaded_q |=> $stable(fw_q) && $stable(la_q) && $stable(el_q) &&
         $stable(ps_q) && $stable(vc_q);
   endproperty
   a_stable: assert property (p_stable)
      else $error("value changed");

   property p_read;
      @(posedge core_clk) disable iff (!reset_n)
      rd_offset == ccb_pkg::CCB_OFS_PWR_STATE |=> rd_data == $past(ps_q);
   endproperty
   a_read: assert property (p_read) else $error("read mismatch");

   // Unmapped offsets read as empty, never as an alias
   property p_miss;
      @(posedge core_clk) disable iff (!reset_n)
      (rd_offset < ccb_pkg::CCB_OFS_FW_CAP ||
         rd_offset > ccb_pkg::CCB_OFS_VENDOR_CFG) |=>
         !rd_hit && rd_data == ccb_pkg::CCB_BYTE_RESET;
   endproperty
   a_miss: assert property (p_miss)
      else $error("unmapped read not empty");

   c_load: cover property (@(posedge core_clk) $rose(loaded_q));
   c_full: cover property (@(posedge core_clk) ps_q == 8'h1F);
   c_miss: cover property (@(posedge core_clk) loaded_q && !rd_hit);
   c_hit: cover property (@(posedge core_clk) loaded_q && rd_hit);
endmodule : ccb_capability_bytes

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the capability byte table.
// Assumes: Straps are captured at the first edge after reset release.
// Notes: Each strap set is applied under a fresh reset.
`timescale 1ns/1ps
module tb_top;
   logic core_clk;
   logic reset_n;
   logic cfg_slot1_read_only;
   logic cfg_health_per_ns;
   logic [8:0] cfg_err_entries;
   logic [5:0] cfg_power_states;
   logic cfg_vendor_std_format;
   logic [9:0] rd_offset;
   logic [7:0] fw_byte, log_byte, err_byte, pwr_byte, vnd_byte, rd_data;
   logic caps_valid;
   logic rd_hit;
   int mismatches;
   int n_compared;

   ccb_capability_bytes i_dut (.core_clk(core_clk), .reset_n(reset_n),
      .cfg_slot1_read_only(cfg_slot1_read_only),
      .cfg_health_per_ns(cfg_health_per_ns),
      .cfg_err_entries(cfg_err_entries), .cfg_power_states(cfg_power_states),
      .cfg_vendor_std_format(cfg_vendor_std_format), .rd_offset(rd_offset),
      .fw_capability_byte(fw_byte), .log_attribute_byte(log_byte),
      .error_log_entry_count(err_byte), .power_state_count(pwr_byte),
      .vendor_command_config_byte(vnd_byte), .caps_valid(caps_valid),
      .rd_data(rd_data), .rd_hit(rd_hit));

   // ----------------------------------------------------------------
   // Compare and report
   // ----------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic check_caps(input logic [39:0] e);
      chk_byte(fw_byte, e[39:32]);
      chk_byte(log_byte, e[31:24]);
      chk_byte(err_byte, e[23:16]);
      chk_byte(pwr_byte, e[15:8]);
      chk_byte(vnd_byte, e[7:0]);
      chk_bit(caps_valid, 1'b1);
   endtask : check_caps

   // Back-to-back reads; each answer lands one edge after its offset
   task automatic read_sweep(input logic [39:0] e);
      logic [9:0] ofs;
      logic [9:0] prev;
      logic hit;
      int k;
      for (int j = 0; j <= 8; j++)
      begin
         prev = ofs;
         ofs = (j == 7) ? 10'h304 : 10'h103 + 10'(j);
         @(posedge core_clk);
         rd_offset <= ofs;
         #1;
         if (j > 0)
         begin
            k = int'(prev) - int'(ccb_pkg::CCB_OFS_FW_CAP);
            hit = (k >= 0) && (k <= 4);
            chk_byte(rd_data, hit ? e[8*(4-k) +: 8] : 8'h00);
            chk_bit(rd_hit, hit);
         end
      end
   endtask : read_sweep

   task automatic run_cfg(input logic [17:0] s, input logic [39:0] e);
      @(posedge core_clk);
      reset_n <= 1'b0;
      {cfg_slot1_read_only, cfg_health_per_ns, cfg_err_entries,
         cfg_power_states, cfg_vendor_std_format} <= s;
      repeat (2) @(posedge core_clk);
      #1;
      chk_byte(pwr_byte, 8'h00);
      chk_bit(caps_valid, 1'b0);
      @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      check_caps(e);
      read_sweep(e);
      // Late strap changes must not leak out
      @(posedge core_clk);
      {cfg_slot1_read_only, cfg_health_per_ns, cfg_err_entries,
         cfg_power_states, cfg_vendor_std_format} <= ~s;
      repeat (3) @(posedge core_clk);
      #1;
      check_caps(e);
   endtask : run_cfg

   // ----------------------------------------------------------------
   // Clock, watchdog and sequence
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   initial
   begin
      repeat (4000) @(posedge core_clk);
      mismatches++;
      give_verdict();
   end

   initial
   begin
      mismatches = 0;
      n_compared = 0;
      reset_n = 1'b0;
      {cfg_slot1_read_only, cfg_health_per_ns, cfg_err_entries,
         cfg_power_states, cfg_vendor_std_format, rd_offset} = '0;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      // Limits, minimums, clamps and a mid-range set
      run_cfg({1'b1, 1'b0, 9'h100, 6'h20, 1'b1},
         40'h01_00_FF_1F_01);
      run_cfg({1'b0, 1'b1, 9'h001, 6'h01, 1'b0},
         40'h00_01_00_00_00);
      run_cfg({1'b1, 1'b1, 9'h1FF, 6'h00, 1'b1},
         40'h01_01_FF_00_01);
      run_cfg({1'b0, 1'b0, 9'h000, 6'h3F, 1'b0},
         40'h00_00_00_1F_00);
      run_cfg({1'b0, 1'b0, 9'h010, 6'h05, 1'b0},
         40'h00_00_0F_04_00);
      give_verdict();
   end
endmodule : tb_top
